// ==== rtl/pmrs_defines.svh ====
`ifndef PMRS_DEFINES_SVH
`define PMRS_DEFINES_SVH
// reset stretch after all sources release, in cycles of the 25 MHz clock
`define PMRS_RST_HOLD_CYCLES 8'h10
// mode request encodings
`define PMRS_REQ_NONE 2'h0
`define PMRS_REQ_IDLE 2'h1
`define PMRS_REQ_PD 2'h2
`define PMRS_REQ_TPD 2'h3
`endif

// ==== rtl/pmrs_pkg.sv ====
package pmrs_pkg;
  typedef enum logic [1:0] {
    PMRS_RUN = 2'b00,
    PMRS_IDLE = 2'b01,
    PMRS_PD = 2'b10,
    PMRS_TPD = 2'b11
  } pmrs_mode_type;
endpackage

// ==== rtl/pmrs_power_monitor.sv ====
`timescale 1ns/1ps
`include "pmrs_defines.svh"
module pmrs_power_monitor (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic por_detect_i,
  input wire logic bo_below_i,
  input wire logic bo_enable_i,
  input wire logic bo_irq_mode_i,
  input wire logic reset_pin_select_i,
  input wire logic shared_reset_pin_i,
  input wire logic soft_reset_bit_i,
  input wire logic wdt_reset_i,
  input wire logic [1:0] mode_req_i,
  input wire logic irq_pending_i,
  input wire logic wake_irq_i,
  input wire logic pof_clear_i,
  input wire logic rc_is_sysclk_i,
  input wire logic rtc_enable_i,
  input wire logic cmp_pd_i,
  output logic core_reset_n_o,
  output logic bo_irq_o,
  output logic power_on_flag_o,
  output logic pin_input_o,
  output logic osc_enable_o,
  output logic cpu_clk_enable_o,
  output logic rc_osc_enable_o,
  output logic bo_detect_enable_o,
  output logic cmp_enable_o,
  output pmrs_pkg::pmrs_mode_type mode_o
);
  import pmrs_pkg::*;

  pmrs_mode_type mode_q, mode_d;
  logic [7:0] hold_q, hold_d;
  logic rst_n_q, rst_n_d;
  logic pu_q, pu_d;
  logic pof_q, pof_d;
  logic boi_q, boi_d;
  logic pin_q, pin_d;
  logic osc_q, osc_d, cpu_q, cpu_d, rc_q, rc_d, bod_q, bod_d, cmp_q, cmp_d;
  logic bo_active, bo_cond, pin_reset, any_reset;

  // brownout only exists while enabled and outside total power-down
  assign bo_active = bo_enable_i && (mode_q != PMRS_TPD);
  assign bo_cond = bo_active && bo_below_i;
  // pin is forced to reset duty until the power-up sequence completes
  assign pin_reset = (reset_pin_select_i || pu_q) && !shared_reset_pin_i;
  assign any_reset = por_detect_i || (bo_cond && !bo_irq_mode_i) || pin_reset
                     || soft_reset_bit_i || wdt_reset_i;

  // reset merge and stretch; release is counted so it is synchronous
  always_comb begin
    hold_d = hold_q;
    rst_n_d = rst_n_q;
    pu_d = pu_q;
    if (any_reset) begin
      hold_d = `PMRS_RST_HOLD_CYCLES;
      rst_n_d = 1'b0;
    end else if (hold_q != 8'h00) begin
      hold_d = hold_q - 8'h01;
    end else begin
      rst_n_d = 1'b1;
      pu_d = 1'b0; // power-up sequence ends at first release
    end
    if (por_detect_i) begin
      pu_d = 1'b1;
    end
  end

  // flags: power-on wins over software clear so the event is not lost
  always_comb begin
    pof_d = pof_q;
    if (pof_clear_i) begin
      pof_d = 1'b0;
    end
    if (por_detect_i) begin
      pof_d = 1'b1;
    end
    boi_d = bo_cond && bo_irq_mode_i;
    pin_d = shared_reset_pin_i && !reset_pin_select_i && !pu_q;
  end

  // power mode sequencing; reset always returns to run
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      PMRS_RUN: begin
        if (mode_req_i == `PMRS_REQ_IDLE) begin
          mode_d = PMRS_IDLE;
        end else if (mode_req_i == `PMRS_REQ_PD) begin
          mode_d = PMRS_PD;
        end else if (mode_req_i == `PMRS_REQ_TPD) begin
          mode_d = PMRS_TPD;
        end
      end
      PMRS_IDLE: begin
        if (irq_pending_i || boi_q) begin
          mode_d = PMRS_RUN;
        end
      end
      default: begin
        if (wake_irq_i) begin
          mode_d = PMRS_RUN;
        end
      end
    endcase
    if (any_reset) begin
      mode_d = PMRS_RUN;
    end
  end

  // clock and analog enables follow the next mode so they change with it
  always_comb begin
    osc_d = (mode_d == PMRS_RUN) || (mode_d == PMRS_IDLE);
    cpu_d = (mode_d == PMRS_RUN);
    rc_d = osc_d || (rc_is_sysclk_i && rtc_enable_i);
    bod_d = bo_enable_i && (mode_d != PMRS_TPD);
    cmp_d = !cmp_pd_i && (mode_d != PMRS_TPD);
  end

  // registers; sleep entry is no reset source, so ram outside keeps its contents
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= PMRS_RUN;
      hold_q <= `PMRS_RST_HOLD_CYCLES;
      rst_n_q <= 1'b0;
      pu_q <= 1'b1;
      pof_q <= 1'b1;
      boi_q <= 1'b0;
      pin_q <= 1'b0;
      osc_q <= 1'b1;
      cpu_q <= 1'b1;
      rc_q <= 1'b1;
      bod_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      hold_q <= hold_d;
      rst_n_q <= rst_n_d;
      pu_q <= pu_d;
      pof_q <= pof_d;
      boi_q <= boi_d;
      pin_q <= pin_d;
      osc_q <= osc_d;
      cpu_q <= cpu_d;
      rc_q <= rc_d;
      bod_q <= bod_d;
      cmp_q <= cmp_d;
    end
  end

  assign core_reset_n_o = rst_n_q;
  assign bo_irq_o = boi_q;
  assign power_on_flag_o = pof_q;
  assign pin_input_o = pin_q;
  assign osc_enable_o = osc_q;
  assign cpu_clk_enable_o = cpu_q;
  assign rc_osc_enable_o = rc_q;
  assign bo_detect_enable_o = bod_q;
  assign cmp_enable_o = cmp_q;
  assign mode_o = mode_q;

  // assertions
  bo_reset_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (bo_enable_i && bo_below_i && !bo_irq_mode_i && mode_q != PMRS_TPD) |=> !core_reset_n_o)
    else $error("brownout did not reset");
  bo_irq_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (bo_enable_i && bo_below_i && bo_irq_mode_i && mode_q != PMRS_TPD) |=> bo_irq_o)
    else $error("brownout irq missing");
  bo_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !bo_enable_i |=> !bo_irq_o && !bo_detect_enable_o)
    else $error("disabled brownout active");
  pof_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (power_on_flag_o && !pof_clear_i) |=> power_on_flag_o)
    else $error("power-on flag lost");
  pof_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    por_detect_i |=> power_on_flag_o && !core_reset_n_o)
    else $error("power-on not seen");
  idle_wake_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_q == PMRS_IDLE && irq_pending_i) |=> mode_q == PMRS_RUN && cpu_clk_enable_o)
    else $error("idle not ended");
  pd_osc_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_q == PMRS_PD || mode_q == PMRS_TPD) |-> !osc_enable_o && !cpu_clk_enable_o)
    else $error("oscillator runs in power-down");
  tpd_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    mode_q == PMRS_TPD |-> !bo_detect_enable_o && !cmp_enable_o)
    else $error("analog on in total power-down");
  pin_reset_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (reset_pin_select_i && !shared_reset_pin_i) |=> !core_reset_n_o [*2])
    else $error("pin reset not held");
  soft_rst_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(soft_reset_bit_i) && !any_reset |-> !core_reset_n_o ##16 !core_reset_n_o ##1 core_reset_n_o)
    else $error("reset release timing wrong");
  pd_wake_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode_q == PMRS_PD && wake_irq_i) |=> mode_q == PMRS_RUN)
    else $error("power-down not left");

  idle_c: cover property (@(posedge clk_i) mode_q == PMRS_IDLE ##[1:20] mode_q == PMRS_RUN);
  pd_c: cover property (@(posedge clk_i) mode_q == PMRS_PD ##[1:20] mode_q == PMRS_RUN);
  tpd_c: cover property (@(posedge clk_i) mode_q == PMRS_TPD);
  bo_irq_c: cover property (@(posedge clk_i) bo_irq_o);
endmodule

// ==== verification/pmrs_reset_partner.sv ====
`timescale 1ns/1ps
// outside reset circuit: a pull-up keeps the pin high unless the bench presses it
module pmrs_reset_partner (
  input wire logic press_i,
  output logic pin_o
);
  // never low by itself, so power-on can finish
  assign pin_o = press_i ? 1'b0 : 1'b1;
endmodule

// ==== verification/test_power_monitor_reset_and_sleep.sv ====
`timescale 1ns/1ps
`include "pmrs_defines.svh"
module test_power_monitor_reset_and_sleep;
  import pmrs_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, por_detect_i = 1'b0, bo_below_i = 1'b0;
  logic bo_enable_i = 1'b0, bo_irq_mode_i = 1'b0, reset_pin_select_i = 1'b1, press = 1'b0;
  logic soft_reset_bit_i = 1'b0, irq_pending_i = 1'b0, wake_irq_i = 1'b0, pof_clear_i = 1'b0;
  logic rc_is_sysclk_i = 1'b0, rtc_enable_i = 1'b0, cmp_pd_i = 1'b0, wdt_reset_i = 1'b0;
  logic [1:0] mode_req_i = 2'h0;
  logic [16:0] seed = 17'h1364C;
  wire logic shared_reset_pin_i;
  logic core_reset_n_o, bo_irq_o, power_on_flag_o, pin_input_o, osc_enable_o;
  logic cpu_clk_enable_o, rc_osc_enable_o, bo_detect_enable_o, cmp_enable_o;
  pmrs_mode_type mode_o;
  int n_mismatch = 0, samples_checked = 0;
  pmrs_reset_partner partner (.press_i(press), .pin_o(shared_reset_pin_i));
  pmrs_power_monitor DUT (.clk_i, .reset_n_i, .por_detect_i, .bo_below_i, .bo_enable_i,
    .bo_irq_mode_i, .reset_pin_select_i, .shared_reset_pin_i, .soft_reset_bit_i,
    .wdt_reset_i, .mode_req_i, .irq_pending_i, .wake_irq_i, .pof_clear_i,
    .rc_is_sysclk_i, .rtc_enable_i, .cmp_pd_i, .core_reset_n_o, .bo_irq_o,
    .power_on_flag_o, .pin_input_o, .osc_enable_o, .cpu_clk_enable_o, .rc_osc_enable_o,
    .bo_detect_enable_o, .cmp_enable_o, .mode_o);
  // 25 MHz clock
  always #20 clk_i = ~clk_i;
  function automatic logic [16:0] lfsr(logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_i);
  endtask
  // reset must stretch the full hold after its last source drops
  task automatic rel_chk(string what);
    cyc(`PMRS_RST_HOLD_CYCLES);
    chk(what, 8'h00, 8'(core_reset_n_o));
    cyc(1);
    chk(what, 8'h01, 8'(core_reset_n_o));
  endtask
  task automatic tally_and_finish;
    $display("counts: %0d checks, %0d mismatches", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  // main sequence, inputs change on the falling edge
  initial begin
    cyc(2);
    reset_n_i = 1'b1;
    chk("pof", 8'h01, 8'(power_on_flag_o));
    rel_chk("cold rst");
    pof_clear_i = 1'b1;
    cyc(1);
    pof_clear_i = 1'b0;
    cyc(1);
    chk("pof clr", 8'h00, 8'(power_on_flag_o));
    por_detect_i = 1'b1;
    cyc(2);
    chk("por rst", 8'h00, 8'(core_reset_n_o));
    chk("pof set", 8'h01, 8'(power_on_flag_o));
    por_detect_i = 1'b0;
    rel_chk("por rel");
    soft_reset_bit_i = 1'b1;
    cyc(2);
    chk("soft rst", 8'h00, 8'(core_reset_n_o));
    soft_reset_bit_i = 1'b0;
    rel_chk("soft rel");
    wdt_reset_i = 1'b1;
    cyc(2);
    chk("wdt rst", 8'h00, 8'(core_reset_n_o));
    wdt_reset_i = 1'b0;
    rel_chk("wdt rel");
    $display("test reset sources done");
    bo_enable_i = 1'b1;
    bo_below_i = 1'b1;
    cyc(2);
    chk("bo rst", 8'h00, 8'(core_reset_n_o));
    bo_below_i = 1'b0;
    rel_chk("bo rel");
    bo_irq_mode_i = 1'b1;
    bo_below_i = 1'b1;
    cyc(2);
    chk("bo irq", 8'h01, 8'(bo_irq_o));
    chk("bo no rst", 8'h01, 8'(core_reset_n_o));
    bo_below_i = 1'b0;
    cyc(2);
    chk("bo irq off", 8'h00, 8'(bo_irq_o));
    bo_enable_i = 1'b0;
    bo_below_i = 1'b1;
    cyc(2);
    chk("bo off", 8'h00, 8'(bo_irq_o));
    // supply may sag below the trip level, so detection stays off: no reset storm
    bo_irq_mode_i = 1'b0;
    cyc(2);
    chk("bo off no rst", 8'h01, 8'(core_reset_n_o));
    bo_below_i = 1'b0;
    bo_enable_i = 1'b1;
    $display("test brownout done");
    press = 1'b1;
    cyc(2);
    chk("pin rst", 8'h00, 8'(core_reset_n_o));
    press = 1'b0;
    rel_chk("pin rel");
    // plain input: random pin levels must pass through and never reset
    reset_pin_select_i = 1'b0;
    repeat (8) begin
      seed = lfsr(seed);
      press = ~seed[0];
      cyc(3);
      chk("pin in", 8'(seed[0]), 8'(pin_input_o));
      chk("pin no rst", 8'h01, 8'(core_reset_n_o));
    end
    press = 1'b0;
    $display("test pin done");
    // every sleep mode: idle woken by a pending irq, power-down and total power-down by the wake irq
    for (int r = 1; r < 4; r++) begin
      seed = lfsr(seed);
      rc_is_sysclk_i = seed[1];
      rtc_enable_i = seed[2];
      mode_req_i = 2'(r);
      cyc(1);
      mode_req_i = 2'h0;
      cyc(1);
      chk("mode", 8'(r), 8'(mode_o));
      chk("cpu clk", 8'h00, 8'(cpu_clk_enable_o));
      chk("osc", 8'(r == 1), 8'(osc_enable_o));
      chk("rc osc", 8'(r == 1 || (seed[1] && seed[2])), 8'(rc_osc_enable_o));
      chk("bod", 8'(r != 3), 8'(bo_detect_enable_o));
      chk("cmp", 8'(r != 3), 8'(cmp_enable_o));
      if (r == 1)
        irq_pending_i = 1'b1;
      else
        wake_irq_i = 1'b1;
      cyc(1);
      irq_pending_i = 1'b0;
      wake_irq_i = 1'b0;
      cyc(1);
      chk("wake", 8'h00, 8'(mode_o));
      chk("cpu on", 8'h01, 8'(cpu_clk_enable_o));
    end
    // every sleep mode left by a reset, the safe wake after a retention-level supply
    for (int r = 1; r < 4; r++) begin
      mode_req_i = 2'(r);
      cyc(1);
      mode_req_i = 2'h0;
      chk("sleep entry", 8'(r), 8'(mode_o));
      chk("sleep no rst", 8'h01, 8'(core_reset_n_o));
      soft_reset_bit_i = 1'b1;
      cyc(1);
      soft_reset_bit_i = 1'b0;
      chk("rst wake", 8'h00, 8'(mode_o));
      chk("rst wake core", 8'h00, 8'(core_reset_n_o));
      rel_chk("rst wake rel");
    end
    $display("test modes done");
    tally_and_finish();
  end
endmodule
